// ---- hw/ccu_pkg.sv ----
// package of constants and types for the clock update and reset controller
//
// Overview of operation
// (RL1) PLL settings apply only on update bit
// (RL2) full relock waits 520 reference periods
// (RL3) glitchless source switch during PLL lock
// (RL4) divider-exponent-only change waits ten periods
// (RL5) software gates unmanaged PLL clocks first
// (RL6) PLL, divider and source update separately
// (RL7) other PLL used while one relocks
// (RL8) reset presets give 96 MHz clocks
// (RL9) integer dividers span one to sixty-four
// (RL10) fixed halves and selectable four-three-two-one dividers
// (RL11) software changes managed clocks via update register
// (RL12) software never gates memory interface clock
// (RL13) core at most 347.5, bus 120 MHz
// (RL14) array memory 360, compute 180 MHz max
// (RL15) PLL outputs within per-PLL maxima
// (RL16) peripheral reference clocks at most 133 MHz
// (RL17) memory clock independent of bus clock
// (RL18) memory timing writable only in config state
// (RL19) read data invalid until delay line relocks
// (RL20) pin held one second, then 500-period wait
// (RL21) pin, loader, registers, watchdog all reset
// (RL22) board straps secure low, boot-mode high
// (RL23) PLL fields eight, five, three bits wide
// (RL24) two straps select preset PLL configuration
// (RL25) outgoing clock stops low, incoming synchronised first
package ccu_pkg;
	// ========================================================
	// register map
	localparam logic [7:0] CCU_ADDR_SYS_PLL   = 8'h00;
	localparam logic [7:0] CCU_ADDR_ARR_PLL   = 8'h04;
	localparam logic [7:0] CCU_ADDR_CLK_SEL   = 8'h08;
	localparam logic [7:0] CCU_ADDR_UPDATE    = 8'h0C;
	localparam logic [7:0] CCU_ADDR_STATUS    = 8'h10;
	localparam logic [7:0] CCU_ADDR_RESET_REQ = 8'h14;
	localparam logic [7:0] CCU_ADDR_MEM_CTL   = 8'h18;
	localparam logic [7:0] CCU_ADDR_MEM_TIM   = 8'h1C;
	// ========================================================
	// PLL word: feedback [7:0], reference [12:8], exponent [15:13]
	localparam int CCU_FB_LSB  = 0;
	localparam int CCU_REF_LSB = 8;
	localparam int CCU_EXP_LSB = 13;
	localparam int CCU_PLL_W   = 16;
	// update register bits
	localparam int CCU_UPD_SYS = 0;
	localparam int CCU_UPD_ARR = 1;
	localparam int CCU_UPD_SEL = 2;
	// clock select word: src [0], integer div-1 [6:1], choice div [8:7]
	localparam int CCU_SEL_W   = 9;
	// ========================================================
	// timing, in reference clock periods
	localparam int CCU_LOCK_FULL   = 520;
	localparam int CCU_LOCK_EXP    = 10;
	localparam int CCU_RESET_WAIT  = 500;
	localparam int CCU_DLL_LOCK    = 64;
	localparam int CCU_CNT_W       = 10;
	// ========================================================
	// reset values: 24 MHz preset, feedback 31, ref 0, exp 4 -> 96 MHz
	localparam logic [15:0] CCU_PRESET_13 = 16'h4CBF;
	localparam logic [15:0] CCU_PRESET_19 = 16'h8027;
	localparam logic [15:0] CCU_PRESET_24 = 16'h801F;
	localparam logic [15:0] CCU_PRESET_27 = 16'h88FF;
	localparam logic [8:0]  CCU_SEL_RST   = 9'h000;
	localparam logic [1:0]  CCU_RESP_OK   = 2'b00;
	localparam logic [1:0]  CCU_RESP_ERR  = 2'b10;

	typedef enum logic [1:0] {
		CCU_IDLE  = 2'b00,
		CCU_LOCK  = 2'b01,
		CCU_RSTW  = 2'b10
	} ccu_state_t;

	// preset PLL word selected by the reference strap
	function automatic logic [15:0] ccu_preset(input logic [1:0] strap);
		case (strap)
			2'b00:   ccu_preset = CCU_PRESET_13;
			2'b01:   ccu_preset = CCU_PRESET_19;
			2'b11:   ccu_preset = CCU_PRESET_27;
			default: ccu_preset = CCU_PRESET_24;
		endcase
	endfunction
endpackage

// ---- hw/ccu_clk_div.sv ----
// integer and choice clock divider with glitchless enable
`timescale 1ns/1ps
module ccu_clk_div
	import ccu_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       src_on,
	input  wire logic [5:0] int_div_m1,
	input  wire logic [1:0] choice_sel,
	output logic            clk_en_ff
);
	logic [5:0] cnt_ff;
	logic [5:0] nxt_cnt;
	logic [7:0] limit;
	logic       on_meta_ff;
	logic       on_sync_ff;

	// enable crosses in two stages so a restart never cuts a pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_meta_ff <= 1'b0;
			on_sync_ff <= 1'b0;
		end else begin
			on_meta_ff <= src_on;
			on_sync_ff <= on_meta_ff; // RL25
		end
	end

	// choice ratio /1../4 stacked on integer /1../64; a product above 64 runs at /1
	always_comb begin
		limit = 8'(({2'b00, int_div_m1} + 8'h01) * ({6'h00, choice_sel} + 8'h01) - 8'h01); // RL9 RL10
		nxt_cnt = (8'({2'b00, cnt_ff}) >= limit || limit > 8'h3F) ? 6'h00 : cnt_ff + 6'h01;
	end

	// pulse ends at a period boundary, so the gated clock stops low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff    <= 6'h00;
			clk_en_ff <= 1'b0;
		end else if (!on_sync_ff) begin
			cnt_ff    <= 6'h00;
			clk_en_ff <= 1'b0; // RL25
		end else begin
			cnt_ff    <= nxt_cnt;
			clk_en_ff <= (nxt_cnt == 6'h00);
		end
	end
endmodule

// ---- hw/ccu_top.sv ----
// clock update, PLL lock sequencing and reset controller top
`timescale 1ns/1ps
module ccu_top
	import ccu_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ref_tick,
	input  wire logic [1:0]  ref_strap,
	input  wire logic        external_reset_pin_n,
	input  wire logic        boot_reset_req,
	input  wire logic        wdog_reset_req,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [15:0]      sys_pll_cfg_ff,
	output logic [15:0]      array_pll_cfg_ff,
	output logic             sys_pll_valid_ff,
	output logic             array_pll_valid_ff,
	output logic             src_is_array_ff,
	output logic             core_clk_en,
	output logic             bus_clk_en,
	output logic             internal_reset_n_ff,
	output logic             mem_access_block_ff,
	output logic             mem_read_valid_ff,
	output logic [31:0]      mem_timing_ff
);
	// ========================================================
	// state
	ccu_state_t state_ff;
	ccu_state_t nxt_state;
	logic [15:0]       sys_stage_ff;
	logic [15:0]       arr_stage_ff;
	logic [8:0]        sel_stage_ff;
	logic [8:0]        sel_live_ff;
	logic [CCU_CNT_W-1:0] lock_cnt_ff;
	logic              lock_arr_ff;
	logic              pend_sel_ff;
	logic              sw_reset_ff;
	logic              mem_cfg_ff;
	logic              mem_clk_chg_ff;
	logic [6:0]        dll_cnt_ff;
	logic              aw_ok_ff;
	logic              w_ok_ff;
	logic [7:0]        awaddr_ff;
	logic [31:0]       wdata_ff;
	logic [3:0]        wstrb_ff;
	logic              wr_fire;
	logic              upd_sys;
	logic              upd_arr;
	logic              upd_sel;
	logic              any_reset;
	logic              src_ok;
	logic              arr_locking;
	logic [31:0]       wmask;

	// expand byte strobes into a bit mask
	function automatic logic [31:0] ccu_mask(input logic [3:0] s);
		ccu_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// ========================================================
	// AXI write channel: address and data taken in either order
	assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
	assign s_axi_wready  = !w_ok_ff && !s_axi_bvalid;
	assign wr_fire       = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
	assign wmask         = ccu_mask(wstrb_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_ff  <= 1'b0;
			w_ok_ff   <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_ff  <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_ok_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_ff  <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_ok_ff <= 1'b0;
			end
		end
	end

	// write response; addresses past the register map answer with slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CCU_RESP_OK;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_ff[7:2] > CCU_ADDR_MEM_TIM[7:2]) ? CCU_RESP_ERR : CCU_RESP_OK;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ========================================================
	// staged settings: writes only stage, the kick applies them
	assign upd_sys = wr_fire && awaddr_ff == CCU_ADDR_UPDATE && wmask[CCU_UPD_SYS] && wdata_ff[CCU_UPD_SYS];
	assign upd_arr = wr_fire && awaddr_ff == CCU_ADDR_UPDATE && wmask[CCU_UPD_ARR] && wdata_ff[CCU_UPD_ARR];
	assign upd_sel = wr_fire && awaddr_ff == CCU_ADDR_UPDATE && wmask[CCU_UPD_SEL] && wdata_ff[CCU_UPD_SEL];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_stage_ff <= 16'h0000;
			arr_stage_ff <= 16'h0000;
			sel_stage_ff <= CCU_SEL_RST;
		end else if (state_ff == CCU_RSTW && lock_cnt_ff == '0) begin
			sys_stage_ff <= ccu_preset(ref_strap); // RL24
			arr_stage_ff <= ccu_preset(ref_strap);
		end else if (wr_fire) begin
			if (awaddr_ff == CCU_ADDR_SYS_PLL)
				sys_stage_ff <= (sys_stage_ff & ~wmask[15:0]) | (wdata_ff[15:0] & wmask[15:0]); // RL23
			if (awaddr_ff == CCU_ADDR_ARR_PLL)
				arr_stage_ff <= (arr_stage_ff & ~wmask[15:0]) | (wdata_ff[15:0] & wmask[15:0]);
			if (awaddr_ff == CCU_ADDR_CLK_SEL)
				sel_stage_ff <= (sel_stage_ff & ~wmask[8:0]) | (wdata_ff[8:0] & wmask[8:0]);
		end
	end

	// ========================================================
	// lock sequencer; lock counts advance on reference ticks
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CCU_RSTW: if (ref_tick && lock_cnt_ff == CCU_CNT_W'(CCU_RESET_WAIT)) nxt_state = CCU_IDLE; // RL20
			CCU_IDLE: if (upd_sys || upd_arr) nxt_state = CCU_LOCK;
			CCU_LOCK: if (ref_tick && lock_cnt_ff == '0) nxt_state = CCU_IDLE;
			default:  nxt_state = CCU_RSTW;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || any_reset) begin
			state_ff <= CCU_RSTW;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// one PLL relocks at a time; exponent-only change gets the short wait
	always_ff @(posedge aclk) begin
		if (!aresetn || any_reset) begin
			lock_cnt_ff      <= '0;
			lock_arr_ff      <= 1'b0;
			sys_pll_cfg_ff   <= 16'h0000;
			array_pll_cfg_ff <= 16'h0000;
		end else begin
			case (state_ff)
				CCU_RSTW: begin
					if (ref_tick)
						lock_cnt_ff <= lock_cnt_ff + 1'b1;
					if (lock_cnt_ff == 1) begin
						sys_pll_cfg_ff   <= sys_stage_ff; // RL8
						array_pll_cfg_ff <= arr_stage_ff;
					end
					if (nxt_state == CCU_IDLE)
						lock_cnt_ff <= '0;
				end
				CCU_IDLE: begin
					if (upd_sys) begin
						lock_arr_ff    <= 1'b0;
						sys_pll_cfg_ff <= sys_stage_ff; // RL1
						lock_cnt_ff    <= (sys_stage_ff[12:0] == sys_pll_cfg_ff[12:0]) ?
							CCU_CNT_W'(CCU_LOCK_EXP) : CCU_CNT_W'(CCU_LOCK_FULL); // RL2 RL4
					end else if (upd_arr) begin
						lock_arr_ff      <= 1'b1;
						array_pll_cfg_ff <= arr_stage_ff; // RL1
						lock_cnt_ff      <= (arr_stage_ff[12:0] == array_pll_cfg_ff[12:0]) ?
							CCU_CNT_W'(CCU_LOCK_EXP) : CCU_CNT_W'(CCU_LOCK_FULL); // RL2 RL4
					end
				end
				CCU_LOCK: if (ref_tick && lock_cnt_ff != '0) lock_cnt_ff <= lock_cnt_ff - 1'b1;
				default: lock_cnt_ff <= '0;
			endcase
		end
	end

	// which PLL relocks as seen at this edge; lock_arr_ff alone lags one cycle
	// and would drop the wrong valid flag on the kick edge
	assign arr_locking = (state_ff == CCU_IDLE) ? (upd_arr && !upd_sys) : lock_arr_ff;

	// PLL valid flags drop during the reset wait and their own lock interval only
	always_ff @(posedge aclk) begin
		if (!aresetn || any_reset) begin
			sys_pll_valid_ff   <= 1'b0;
			array_pll_valid_ff <= 1'b0;
		end else begin
			sys_pll_valid_ff   <= (nxt_state == CCU_IDLE) || (nxt_state == CCU_LOCK && arr_locking);
			array_pll_valid_ff <= (nxt_state == CCU_IDLE) || (nxt_state == CCU_LOCK && !arr_locking);
		end
	end

	// ========================================================
	// source select: a pending change waits for the target PLL
	always_ff @(posedge aclk) begin
		if (!aresetn || any_reset) begin
			sel_live_ff     <= CCU_SEL_RST;
			src_is_array_ff <= 1'b0;
			pend_sel_ff     <= 1'b0;
		end else begin
			if (pend_sel_ff && !core_clk_en && (sel_stage_ff[0] ? array_pll_valid_ff : sys_pll_valid_ff)) begin
				sel_live_ff     <= sel_stage_ff; // RL7
				src_is_array_ff <= sel_stage_ff[0];
				pend_sel_ff     <= 1'b0;
			end
			// a kick in the apply cycle stays pending: the set wins
			if (upd_sel)
				pend_sel_ff <= 1'b1; // RL6
		end
	end

	// the running source is paused while it relocks or a switch is due
	assign src_ok = (src_is_array_ff ? array_pll_valid_ff : sys_pll_valid_ff) && !pend_sel_ff; // RL3

	ccu_clk_div u_core_div (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.src_on     (src_ok),
		.int_div_m1 (sel_live_ff[6:1]),
		.choice_sel (2'b00),
		.clk_en_ff  (core_clk_en)
	);

	// bus clock is the core clock further divided by the choice ratio while the product stays within 64
	ccu_clk_div u_bus_div (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.src_on     (src_ok),
		.int_div_m1 (sel_live_ff[6:1]),
		.choice_sel (sel_live_ff[8:7]),
		.clk_en_ff  (bus_clk_en)
	);

	// ========================================================
	// reset sources: pin, boot loader, software and watchdog
	assign any_reset = !external_reset_pin_n || boot_reset_req || wdog_reset_req || sw_reset_ff; // RL21

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_reset_ff <= 1'b0;
		end else begin
			sw_reset_ff <= wr_fire && awaddr_ff == CCU_ADDR_RESET_REQ && wmask[0] && wdata_ff[0];
		end
	end

	// internal reset holds until the PLL wait has finished
	always_ff @(posedge aclk) begin
		if (!aresetn || any_reset) begin
			internal_reset_n_ff <= 1'b0;
		end else begin
			internal_reset_n_ff <= (state_ff != CCU_RSTW); // RL20
		end
	end

	// ========================================================
	// memory side: own clock untouched by bus changes
	always_ff @(posedge aclk) begin
		if (!aresetn || !internal_reset_n_ff) begin
			mem_cfg_ff     <= 1'b0;
			mem_clk_chg_ff <= 1'b0;
			mem_timing_ff  <= 32'h0000_0000;
		end else begin
			mem_clk_chg_ff <= wr_fire && awaddr_ff == CCU_ADDR_MEM_CTL && wmask[8] && wdata_ff[1];
			if (wr_fire && awaddr_ff == CCU_ADDR_MEM_CTL && wmask[0])
				mem_cfg_ff <= wdata_ff[0];
			if (wr_fire && awaddr_ff == CCU_ADDR_MEM_TIM && mem_cfg_ff)
				mem_timing_ff <= (mem_timing_ff & ~wmask) | (wdata_ff & wmask); // RL18
		end
	end

	// accesses blocked in config; reads held invalid while delay line relocks
	always_ff @(posedge aclk) begin
		if (!aresetn || !internal_reset_n_ff) begin
			dll_cnt_ff          <= 7'h00;
			mem_access_block_ff <= 1'b1;
			mem_read_valid_ff   <= 1'b0;
		end else begin
			mem_access_block_ff <= mem_cfg_ff; // RL18 RL17
			if (mem_clk_chg_ff)
				dll_cnt_ff <= 7'(CCU_DLL_LOCK);
			else if (ref_tick && dll_cnt_ff != 7'h00)
				dll_cnt_ff <= dll_cnt_ff - 7'h01;
			mem_read_valid_ff <= (dll_cnt_ff == 7'h00) && !mem_clk_chg_ff; // RL19
		end
	end

	// ========================================================
	// read channel: one cycle to answer, held until rready
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= CCU_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= CCU_RESP_OK;
			case (s_axi_araddr)
				CCU_ADDR_SYS_PLL:   s_axi_rdata <= {sys_pll_cfg_ff, sys_stage_ff};
				CCU_ADDR_ARR_PLL:   s_axi_rdata <= {array_pll_cfg_ff, arr_stage_ff};
				CCU_ADDR_CLK_SEL:   s_axi_rdata <= {7'h00, sel_live_ff, 7'h00, sel_stage_ff};
				CCU_ADDR_UPDATE:    s_axi_rdata <= 32'h0000_0000;
				// status: state in bits 7:6, flags below it
				CCU_ADDR_STATUS:    s_axi_rdata <= {24'h000000, state_ff, pend_sel_ff, lock_arr_ff,
					mem_read_valid_ff, src_is_array_ff, array_pll_valid_ff, sys_pll_valid_ff};
				CCU_ADDR_RESET_REQ: s_axi_rdata <= 32'h0000_0000;
				CCU_ADDR_MEM_CTL:   s_axi_rdata <= {31'h00000000, mem_cfg_ff};
				CCU_ADDR_MEM_TIM:   s_axi_rdata <= mem_timing_ff;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= CCU_RESP_ERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ---- dv/ccu_board_model.sv ----
// board side model: reference tick source, strap pulls and reset pin driver
`timescale 1ns/1ps
module ccu_board_model (
	input  wire logic  aclk,
	input  wire logic  press,
	output logic       ref_tick,
	output logic [1:0] ref_strap,
	output logic       external_reset_pin_n
);
	// ========================================================
	// reference clock seen as one aclk in four; a crystal never stops
	logic [1:0] div_ff = 2'h0;
	always_ff @(posedge aclk) begin
		div_ff <= div_ff + 2'h1;
	end
	assign ref_tick = (div_ff == 2'h3);
	// pulls left at the chip default, the 24 MHz preset
	assign ref_strap = 2'h2;
	// pin held low while pressed; the one-second hold is scaled down
	assign external_reset_pin_n = !press;
endmodule

// ---- dv/ccu_checker_assertions.sv ----
// concurrent assertions for the clock update and reset controller
`timescale 1ns/1ps
module ccu_checker
	import ccu_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ref_tick,
	input wire logic        wdog_reset_req,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [15:0] sys_pll_cfg_ff,
	input wire logic        sys_pll_valid_ff,
	input wire logic        array_pll_valid_ff,
	input wire logic        src_is_array_ff,
	input wire logic        core_clk_en,
	input wire logic        internal_reset_n_ff,
	input wire logic        mem_access_block_ff,
	input wire logic [31:0] mem_timing_ff
);
	// ========================================================
	// tick counters for the lock span and the reset wait
	logic [9:0] lcnt_ff;
	logic [9:0] rcnt_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || sys_pll_valid_ff || !internal_reset_n_ff)
			lcnt_ff <= 10'h000;
		else if (ref_tick)
			lcnt_ff <= lcnt_ff + 10'h001;
	end
	// saturates so a long held request cannot wrap it
	always_ff @(posedge aclk) begin
		if (!aresetn || internal_reset_n_ff)
			rcnt_ff <= 10'h000;
		else if (ref_tick && rcnt_ff != 10'h3FF)
			rcnt_ff <= rcnt_ff + 10'h001;
	end
	// ========================================================
	// properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// two sync stages and the enable flop stop the divider three edges late
	sequence s_sys_dead;
		(!sys_pll_valid_ff && !src_is_array_ff) [*4];
	endsequence
	sequence s_relock_done;
		$rose(sys_pll_valid_ff) && lcnt_ff != 10'h000;
	endsequence
	a_lock_span: assert property (s_relock_done |->
		(lcnt_ff >= 10'h008 && lcnt_ff <= 10'h00B) || (lcnt_ff >= 10'h206 && lcnt_ff <= 10'h209))
		else $error("lock span outside expected window");
	a_rst_wait: assert property ($rose(internal_reset_n_ff) |-> rcnt_ff >= 10'h1F3)
		else $error("internal reset released too early");
	a_wdog_reset: assert property (wdog_reset_req |-> ##[1:3] !internal_reset_n_ff)
		else $error("watchdog request did not reset");
	a_cfg_quiet: assert property ($changed(sys_pll_cfg_ff) && $past(internal_reset_n_ff)
		&& internal_reset_n_ff |-> ##[0:1] !sys_pll_valid_ff)
		else $error("pll word changed without relock");
	a_src_ready: assert property ($rose(src_is_array_ff) |-> array_pll_valid_ff)
		else $error("switched to an unlocked source");
	a_clk_stop: assert property (s_sys_dead |-> !core_clk_en)
		else $error("core enable while source invalid");
	a_mem_cfg: assert property ($changed(mem_timing_ff) |-> mem_access_block_ff)
		else $error("memory timing changed outside config");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
endmodule

bind ccu_top ccu_checker ccu_checker_inst (.*);

// ---- dv/test_ccu_top.sv ----
// self-checking testbench for the clock update and reset controller
`timescale 1ns/1ps
module test_ccu_top
	import ccu_pkg::*;
;
	logic        aclk, aresetn, ref_tick, external_reset_pin_n, press;
	logic        boot_reset_req, wdog_reset_req, core_clk_en, bus_clk_en;
	logic [1:0]  ref_strap, s_axi_bresp, s_axi_rresp, resp;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, mem_timing_ff, d;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, sys_pll_valid_ff, array_pll_valid_ff;
	logic        src_is_array_ff, internal_reset_n_ff, mem_access_block_ff, mem_read_valid_ff;
	logic [15:0] sys_pll_cfg_ff, array_pll_cfg_ff, cfg;
	int          checked, err_count, n, p, q;
	int          tbl [4][4] = '{'{0, 0, 128, 128}, '{63, 0, 2, 2}, '{0, 1, 128, 64}, '{0, 3, 128, 32}};

	ccu_top ccu_top_inst (.*);
	ccu_board_model ccu_board_model_inst (.*);

	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// ========================================================
	// compare, verdict and waits
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return internal_reset_n_ff;
			1: return sys_pll_valid_ff;
			2: return src_is_array_ff;
			default: return mem_read_valid_ff;
		endcase
	endfunction
	// cycles until the chosen flag is high; the watchdog bounds it
	task automatic wait_for(input int s, output int c);
		c = 0;
		do begin
			@(negedge aclk);
			c++;
		end while (sig(s) !== 1'b1);
	endtask
	// tick count within two of the target, since kick and start differ by a few cycles
	task automatic near(input int c, input int t);
		chk(32'(c / 4 + 2 >= t && c / 4 <= t + 2), 32'h1);
	endtask
	task automatic count_en(output int pc, output int pb);
		pc = 0;
		pb = 0;
		repeat (128) begin
			@(negedge aclk);
			pc += int'(core_clk_en === 1'b1);
			pb += int'(bus_clk_en === 1'b1);
		end
	endtask
	// ========================================================
	// bus master; ready sampled at the falling edge holds until the next rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(negedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) aw_done = 1'b1;
			if (s_axi_wvalid && s_axi_wready === 1'b1) w_done = 1'b1;
			@(posedge aclk);
			if (aw_done) s_axi_awvalid <= 1'b0;
			if (w_done) s_axi_wvalid <= 1'b0;
		end
		// bready stands from the start; the response is taken where it is sampled
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
		// settle past the edge so callers see what this write launched
		@(negedge aclk);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	// ========================================================
	// watchdog: the whole run needs about 13000 cycles
	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		print_verdict();
	end
	// ========================================================
	// tests; software here sets no gate and leaves unmanaged PLLs alone
	initial begin
		{aresetn, press, boot_reset_req, wdog_reset_req, s_axi_awvalid, s_axi_wvalid} = 6'h00;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 19'h00000;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		wait_for(0, n);
		near(n, CCU_RESET_WAIT);
		wait_for(1, n);
		axi_rd(CCU_ADDR_SYS_PLL, d);
		chk(d[31:16], CCU_PRESET_24);
		chk(array_pll_cfg_ff, CCU_PRESET_24);
		$display("reset preset test done");
		// exponent-only change: held until kicked, then the short lock
		cfg = CCU_PRESET_24 ^ 16'h2000;
		axi_wr(CCU_ADDR_SYS_PLL, {16'h0000, cfg});
		chk(resp, CCU_RESP_OK);
		repeat (8) @(posedge aclk);
		chk(sys_pll_cfg_ff, CCU_PRESET_24);
		axi_wr(CCU_ADDR_UPDATE, 32'h00000001);
		chk(sys_pll_valid_ff, 1'b0);
		wait_for(1, n);
		near(n, CCU_LOCK_EXP);
		chk(sys_pll_cfg_ff, cfg);
		$display("short lock test done");
		// array PLL relocks on its own kick while the system PLL stays up
		axi_wr(CCU_ADDR_ARR_PLL, {16'h0000, cfg});
		axi_wr(CCU_ADDR_UPDATE, 32'h00000002);
		chk(array_pll_valid_ff, 1'b0);
		chk(sys_pll_valid_ff, 1'b1);
		chk(array_pll_cfg_ff, cfg);
		$display("array lock test done");
		// move to the array source, then relock the system pll fully under it
		axi_wr(CCU_ADDR_CLK_SEL, 32'h00000001);
		axi_wr(CCU_ADDR_UPDATE, 32'h00000004);
		wait_for(2, n);
		axi_wr(CCU_ADDR_SYS_PLL, {16'h0000, cfg ^ 16'h0001});
		axi_wr(CCU_ADDR_UPDATE, 32'h00000001);
		count_en(p, q);
		chk(p, 128);
		wait_for(1, n);
		near(n + 128, CCU_LOCK_FULL);
		$display("full lock test done");
		// integer and choice dividers at their bounds
		for (int i = 0; i < 4; i++) begin
			axi_wr(CCU_ADDR_CLK_SEL, {23'h000000, 2'(tbl[i][1]), 6'(tbl[i][0]), 1'b1});
			axi_wr(CCU_ADDR_UPDATE, 32'h00000004);
			repeat (16) @(posedge aclk);
			count_en(p, q);
			chk(p, tbl[i][2]);
			chk(q, tbl[i][3]);
		end
		$display("divider test done");
		axi_rd(8'h20, d);
		chk(resp, CCU_RESP_ERR);
		chk(d, 32'h00000000);
		axi_wr(8'h20, 32'h00000001);
		chk(resp, CCU_RESP_ERR);
		$display("unmapped test done");
		// timing word only takes effect in config state
		axi_wr(CCU_ADDR_MEM_TIM, 32'hA5A50F0F);
		chk(mem_timing_ff === 32'hA5A50F0F, 1'b0);
		axi_wr(CCU_ADDR_MEM_CTL, 32'h00000001);
		chk(mem_access_block_ff, 1'b1);
		axi_wr(CCU_ADDR_MEM_TIM, 32'hA5A50F0F);
		chk(mem_timing_ff, 32'hA5A50F0F);
		axi_wr(CCU_ADDR_MEM_CTL, 32'h00000002);
		chk(mem_access_block_ff, 1'b0);
		chk(mem_read_valid_ff, 1'b0);
		wait_for(3, n);
		near(n, CCU_DLL_LOCK);
		$display("memory config test done");
		// watchdog, loader, pin and register requests each restart the wait
		for (int i = 0; i < 4; i++) begin
			if (i == 3)
				axi_wr(CCU_ADDR_RESET_REQ, 32'h00000001);
			@(posedge aclk);
			{wdog_reset_req, boot_reset_req, press} <= {i == 0, i == 1, i == 2};
			@(posedge aclk);
			{wdog_reset_req, boot_reset_req, press} <= 3'h0;
			repeat (3) @(posedge aclk);
			chk(internal_reset_n_ff, 1'b0);
			wait_for(0, n);
			near(n, CCU_RESET_WAIT);
		end
		$display("reset source test done");
		print_verdict();
	end
endmodule
